// [core/media_mode_consts.svh]
`ifndef MEDIA_MODE_CONSTS_SVH
`define MEDIA_MODE_CONSTS_SVH
// Management register bit positions (bit 15 msb)
`define REG0_SPEED_LSB 6
`define REG0_DUPLEX 8
`define REG0_ANEG_EN 12
`define REG0_SPEED_MSB 13
`define REG23_PREFER_SERIAL 11
`define EXT20_MEDIA_HI 7
`define EXT20_MEDIA_LO 6
`define MGMT_REG_W 16
`define SPEED_10 2'h0
`define SPEED_100 2'h1
`define SPEED_1000 2'h2
`define MEDIA_NONE 2'h0
`define MEDIA_COPPER 2'h1
`define MEDIA_SERIAL 2'h2
`define LED_FORCE_OFF 2'h0
`define LED_FORCE_ON 2'h1
`define LED_LINK 2'h2
`define LINE_RATE_MBAUD 1250
`endif

// [core/media_mode_pkg.sv]
package media_mode_pkg;
	typedef enum logic [1:0] {
		MAC_SERDES,
		MAC_SGMII,
		MAC_SGMII_FX
	} mac_mode_t;
	typedef enum logic {
		SER_PCS_ANEG,
		SER_PASS_THROUGH
	} serial_mode_t;
	typedef struct packed {
		logic [1:0] speed;
		logic full_duplex;
		logic master;
	} resolved_t;
	typedef struct packed {
		logic link;
		logic trying;
	} media_status_t;
endpackage : media_mode_pkg

// [core/media_mode_select.sv]
`timescale 1ns/10ps
`include "media_mode_consts.svh"
// Contract
// - Plain serial MAC carries only gigabit; 10 and 100 refused.
// - Serial media interface runs at 1.25 Gbps, gigabit full or half duplex.
// - Serial PCS autoneg mode shows serial control and status in regs 0-15.
// - Serial PCS autoneg mode limits copper pluggable module to gigabit.
// - Pass-through: regs 0-15 and indicators report no serial link information.
// - Pass-through: indicators honour only forced on and forced off.
// - Pass-through link is up while optical energy input is asserted.
// - Media autoselect picks copper or serial by preference bit 23.11.
// - Preferred media link-up overrides and drops a non-preferred link.
// - Serial preferred: copper links only while serial down; serial holds until loss.
// - Copper preferred: copper when linked or trying; serial only if copper unlinked.
// - Selected media (none, copper, serial) reported in extended reg 20 bits 7:6.
// - Autoselect with serial autoneg: regs 0-15 cover both media.
// - Copper autoneg resolves speed, duplex, role; next pages pass between MACs.
// - Partner without autoneg: parallel detection picks the speed.
// - Clearing reg 0 bit 12 disables copper autoneg.
// - Autoneg off: speed from reg 0 bits 6 and 13, duplex bit 8.
// - SGMII to 100 fiber keeps packet generator, CRC counters, loopback.
// - Register bits numbered 15 msb down to 0 lsb.
module media_mode_select (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire media_mode_pkg::mac_mode_t mac_mode,
	input wire media_mode_pkg::serial_mode_t serial_mode,
	input wire logic media_autoselect,
	input wire logic [`MGMT_REG_W-1:0] ctrl_reg0,
	input wire logic [`MGMT_REG_W-1:0] ctrl_reg23,
	input wire logic [1:0] led_mode,
	input wire logic optical_energy_present,
	input wire media_mode_pkg::media_status_t copper_status,
	input wire media_mode_pkg::media_status_t serial_status,
	input wire media_mode_pkg::resolved_t aneg_result,
	input wire logic aneg_complete,
	input wire logic partner_aneg_able,
	input wire logic [1:0] parallel_speed,
	input wire logic [`MGMT_REG_W-1:0] partner_next_page,
	input wire logic partner_np_valid,
	input wire logic [`MGMT_REG_W-1:0] local_next_page,
	input wire logic local_np_valid,
	output logic [1:0] active_media_q,
	output logic [`MGMT_REG_W-1:0] ext_reg20_q,
	output logic copper_aneg_en_q,
	output logic copper_link_allow_q,
	output logic serial_link_allow_q,
	output media_mode_pkg::resolved_t op_mode_q,
	output logic speed_refused_q,
	output logic copper_sfp_gig_only_q,
	output logic [1:0] mgmt_view_q,
	output logic link_status_q,
	output logic led_out_q,
	output logic fx_test_en_q,
	output logic [`MGMT_REG_W-1:0] np_to_mac_q,
	output logic np_to_mac_valid_q,
	output logic [`MGMT_REG_W-1:0] np_to_line_q,
	output logic np_to_line_valid_q
);
	logic [1:0] energy_sync_q;
	logic pass_link;
	logic prefer_serial;
	logic [1:0] media_d;
	logic serial_up;
	media_mode_pkg::resolved_t op_d;

	// Pin crosses from the optics module, so two stages first
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			energy_sync_q <= 2'h0;
		end else begin
			energy_sync_q <= {energy_sync_q[0], optical_energy_present};
		end
	end

	assign pass_link = energy_sync_q[1];
	assign prefer_serial = ctrl_reg23[`REG23_PREFER_SERIAL];
	assign serial_up = (serial_mode == media_mode_pkg::SER_PASS_THROUGH) ? pass_link
		: serial_status.link;

	// Media arbitration; serial lock-in comes from serial_up alone, active_media_q is not fed back
	always_comb begin
		media_d = `MEDIA_NONE;
		if (!media_autoselect) begin
			media_d = (mac_mode == media_mode_pkg::MAC_SGMII_FX || serial_up) ?
				`MEDIA_SERIAL : (copper_status.link ? `MEDIA_COPPER : `MEDIA_NONE);
			if (mac_mode == media_mode_pkg::MAC_SERDES || mac_mode == media_mode_pkg::MAC_SGMII)
				media_d = copper_status.link ? `MEDIA_COPPER : `MEDIA_NONE;
		end else if (prefer_serial) begin
			if (serial_up) begin
				media_d = `MEDIA_SERIAL;
			end else if (copper_status.link) begin
				media_d = `MEDIA_COPPER;
			end
		end else begin
			if (copper_status.link || copper_status.trying) begin
				media_d = `MEDIA_COPPER;
			end else if (serial_up) begin
				media_d = `MEDIA_SERIAL;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			active_media_q <= `MEDIA_NONE;
			ext_reg20_q <= 16'h0000;
			copper_link_allow_q <= 1'b1;
			serial_link_allow_q <= 1'b1;
		end else begin
			active_media_q <= media_d;
			ext_reg20_q <= '0;
			ext_reg20_q[`EXT20_MEDIA_HI:`EXT20_MEDIA_LO] <= media_d;
			// Copper is held off while serial is up and preferred under autoselect
			copper_link_allow_q <= !(media_autoselect && prefer_serial && serial_up);
			serial_link_allow_q <= !(media_autoselect && !prefer_serial
				&& (copper_status.link || copper_status.trying));
		end
	end

	// Speed and duplex resolution
	always_comb begin
		op_d = '0;
		if (!ctrl_reg0[`REG0_ANEG_EN]) begin
			op_d.speed = {ctrl_reg0[`REG0_SPEED_MSB], ctrl_reg0[`REG0_SPEED_LSB]};
			op_d.full_duplex = ctrl_reg0[`REG0_DUPLEX];
		end else if (!partner_aneg_able) begin
			op_d.speed = parallel_speed;
			op_d.full_duplex = 1'b0;
		end else if (aneg_complete) begin
			op_d = aneg_result;
		end
		// Serial link outside SGMII-FX mode is gigabit only, whatever copper resolved
		if (active_media_q == `MEDIA_SERIAL && mac_mode != media_mode_pkg::MAC_SGMII_FX) begin
			op_d.speed = `SPEED_1000;
		end
		if (mac_mode == media_mode_pkg::MAC_SGMII_FX && active_media_q == `MEDIA_SERIAL) begin
			op_d.speed = `SPEED_100;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_mode_q <= '0;
			speed_refused_q <= 1'b0;
			copper_aneg_en_q <= 1'b1;
			copper_sfp_gig_only_q <= 1'b0;
			fx_test_en_q <= 1'b0;
		end else begin
			copper_aneg_en_q <= ctrl_reg0[`REG0_ANEG_EN];
			// Plain serial MAC can only ship gigabit; flag others and pin speed
			if (mac_mode == media_mode_pkg::MAC_SERDES) begin
				op_mode_q <= '{speed: `SPEED_1000, full_duplex: op_d.full_duplex,
					master: op_d.master};
				speed_refused_q <= (op_d.speed != `SPEED_1000);
			end else begin
				op_mode_q <= op_d;
				speed_refused_q <= 1'b0;
			end
			copper_sfp_gig_only_q <= (serial_mode == media_mode_pkg::SER_PCS_ANEG);
			fx_test_en_q <= (mac_mode == media_mode_pkg::MAC_SGMII_FX);
		end
	end

	// Which media regs 0-15 show: bit0 copper, bit1 serial
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mgmt_view_q <= 2'h0;
			link_status_q <= 1'b0;
			led_out_q <= 1'b0;
		end else begin
			if (serial_mode == media_mode_pkg::SER_PASS_THROUGH) begin
				mgmt_view_q <= {1'b0, media_autoselect};
				link_status_q <= (active_media_q == `MEDIA_COPPER) && copper_status.link;
				led_out_q <= (led_mode == `LED_FORCE_ON);
			end else begin
				mgmt_view_q <= media_autoselect ? 2'h3 : 2'h2;
				link_status_q <= (active_media_q == `MEDIA_COPPER) ? copper_status.link
					: (active_media_q == `MEDIA_SERIAL) && serial_status.link;
				led_out_q <= (led_mode == `LED_FORCE_ON) ||
					((led_mode == `LED_LINK) && active_media_q != `MEDIA_NONE);
			end
		end
	end

	// Next pages pass through in both directions, valid only while reg 0 bit 12 enables autoneg
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			np_to_mac_q <= 16'h0000;
			np_to_mac_valid_q <= 1'b0;
			np_to_line_q <= 16'h0000;
			np_to_line_valid_q <= 1'b0;
		end else begin
			np_to_mac_valid_q <= partner_np_valid && ctrl_reg0[`REG0_ANEG_EN];
			np_to_line_valid_q <= local_np_valid && ctrl_reg0[`REG0_ANEG_EN];
			if (partner_np_valid) begin
				np_to_mac_q <= partner_next_page;
			end
			if (local_np_valid) begin
				np_to_line_q <= local_next_page;
			end
		end
	end
endmodule : media_mode_select

// [test/media_mode_select_props.sv]
`timescale 1ns/10ps
`include "media_mode_consts.svh"
module media_mode_select_props (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire media_mode_pkg::mac_mode_t mac_mode,
	input wire media_mode_pkg::serial_mode_t serial_mode,
	input wire logic media_autoselect,
	input wire logic [15:0] ctrl_reg0,
	input wire logic [15:0] ctrl_reg23,
	input wire logic [1:0] led_mode,
	input wire media_mode_pkg::media_status_t copper_status,
	input wire media_mode_pkg::media_status_t serial_status,
	input wire logic [15:0] local_next_page,
	input wire logic local_np_valid,
	input wire logic [1:0] active_media_q,
	input wire logic [15:0] ext_reg20_q,
	input wire logic copper_aneg_en_q,
	input wire logic copper_link_allow_q,
	input wire media_mode_pkg::resolved_t op_mode_q,
	input wire logic [1:0] mgmt_view_q,
	input wire logic led_out_q,
	input wire logic [15:0] np_to_line_q,
	input wire logic np_to_line_valid_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_media_report: assert property (
		ext_reg20_q[7:6] == active_media_q) else $error("media field differs");
	a_serdes_gig: assert property (
		mac_mode == media_mode_pkg::MAC_SERDES [*3] |-> op_mode_q.speed == `SPEED_1000)
		else $error("serial mac not at gigabit");
	a_aneg_off: assert property (
		!ctrl_reg0[12] |=> !copper_aneg_en_q) else $error("autoneg stays on");
	a_led_forced: assert property (
		led_mode == `LED_FORCE_ON |=> led_out_q) else $error("forced indicator off");
	a_view_both: assert property (
		media_autoselect && serial_mode == media_mode_pkg::SER_PCS_ANEG |=> mgmt_view_q == 2'h3)
		else $error("view lacks a media");
	a_copper_pref: assert property (
		media_autoselect && !ctrl_reg23[11] && (copper_status.link || copper_status.trying)
		|=> active_media_q == `MEDIA_COPPER) else $error("copper not chosen");
	a_serial_pref: assert property (
		media_autoselect && ctrl_reg23[11] && serial_mode == media_mode_pkg::SER_PCS_ANEG
		&& serial_status.link |=> active_media_q == `MEDIA_SERIAL && !copper_link_allow_q)
		else $error("serial not held");
	a_np_line: assert property (
		local_np_valid && ctrl_reg0[12]
		|=> np_to_line_valid_q && np_to_line_q == $past(local_next_page))
		else $error("next page lost");
endmodule : media_mode_select_props

// [test/mac_np_model.sv]
`timescale 1ns/10ps
module mac_np_model (
	input wire logic sys_clk,
	input wire logic send,
	input wire logic [15:0] page,
	output logic [15:0] np_out,
	output logic np_valid
);
	initial np_out = 16'h0000;
	initial np_valid = 1'b0;
	// Idle data toggles so a stale page never passes for a fresh one
	always @(posedge sys_clk) begin
		np_valid <= send;
		np_out <= send ? page : ~np_out;
	end
endmodule : mac_np_model

// [test/media_mode_select_tb_top.sv]
`timescale 1ns/10ps
`include "media_mode_consts.svh"
module media_mode_select_tb_top;
	logic sys_clk = 1'b0, reset_n = 1'b0, media_autoselect = 1'b0, optical_energy_present = 1'b0;
	logic aneg_complete = 1'b0, partner_aneg_able = 1'b1, partner_np_valid = 1'b0, send = 1'b0;
	logic [15:0] ctrl_reg0 = 16'h1000, ctrl_reg23 = 16'h0000, partner_next_page = 16'h0000;
	logic [15:0] page = 16'h0000, local_next_page;
	logic [1:0] led_mode = 2'h0, parallel_speed = 2'h1, active_media_q, mgmt_view_q;
	logic local_np_valid, copper_aneg_en_q, copper_link_allow_q, serial_link_allow_q;
	logic speed_refused_q, copper_sfp_gig_only_q, link_status_q, led_out_q, fx_test_en_q;
	logic np_to_mac_valid_q, np_to_line_valid_q;
	logic [15:0] ext_reg20_q, np_to_mac_q, np_to_line_q;
	media_mode_pkg::mac_mode_t mac_mode = media_mode_pkg::MAC_SGMII;
	media_mode_pkg::serial_mode_t serial_mode = media_mode_pkg::SER_PCS_ANEG;
	media_mode_pkg::media_status_t copper_status = '0, serial_status = '0;
	media_mode_pkg::resolved_t aneg_result = '0, op_mode_q;
	// {prefer serial, copper, serial, expected media}
	logic [6:0] rows [7] = '{7'h61, 7'h6a, 7'h40, 7'h61, 7'h19, 7'h0a, 7'h25};
	int mismatches = 0, check_count = 0, cycles = 0;
	media_mode_select i_media_mode_select (.*);
	mac_np_model i_mac_np_model (.sys_clk(sys_clk), .send(send), .page(page),
		.np_out(local_next_page), .np_valid(local_np_valid));
	always #20 sys_clk = ~sys_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : step
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 400) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		step(3);
		check({active_media_q, copper_aneg_en_q}, 3'h1);
		reset_n = 1'b1;
		media_autoselect = 1'b1;
		foreach (rows[i]) begin
			{ctrl_reg23[11], copper_status, serial_status} = rows[i][6:2];
			step(4);
			check(active_media_q, rows[i][1:0]);
			check(ext_reg20_q[7:6], rows[i][1:0]);
		end
		check(copper_sfp_gig_only_q, 1'b1);
		check(serial_link_allow_q, 1'b0);
		media_autoselect = 1'b0;
		mac_mode = media_mode_pkg::MAC_SERDES;
		ctrl_reg0 = 16'h0000;
		step(4);
		check({op_mode_q.speed, speed_refused_q, copper_aneg_en_q}, 4'ha);
		mac_mode = media_mode_pkg::MAC_SGMII;
		ctrl_reg0 = 16'h0140;
		step(4);
		check({op_mode_q.speed, op_mode_q.full_duplex}, {`SPEED_100, 1'b1});
		ctrl_reg0 = 16'h1000;
		partner_aneg_able = 1'b0;
		step(4);
		check(op_mode_q.speed, 2'h1);
		partner_aneg_able = 1'b1;
		aneg_result = {`SPEED_1000, 2'h3};
		aneg_complete = 1'b1;
		step(4);
		check(op_mode_q, {`SPEED_1000, 2'h3});
		mac_mode = media_mode_pkg::MAC_SGMII_FX;
		serial_mode = media_mode_pkg::SER_PASS_THROUGH;
		led_mode = `LED_FORCE_ON;
		optical_energy_present = 1'b1;
		step(5);
		check({link_status_q, led_out_q, mgmt_view_q[1], fx_test_en_q}, 4'h5);
		led_mode = `LED_LINK;
		step(2);
		check(led_out_q, 1'b0);
		media_autoselect = 1'b1;
		copper_status = '0;
		step(2);
		check(active_media_q, `MEDIA_SERIAL);
		optical_energy_present = 1'b0;
		step(5);
		check(active_media_q, `MEDIA_NONE);
		check(link_status_q, 1'b0);
		page = 16'hbeef;
		send = 1'b1;
		partner_next_page = 16'h5a5a;
		partner_np_valid = 1'b1;
		step(1);
		send = 1'b0;
		partner_np_valid = 1'b0;
		partner_next_page = 16'ha5a5;
		check({np_to_mac_q[14:0], np_to_mac_valid_q}, 16'hb4b5);
		step(1);
		check({np_to_line_q[14:0], np_to_line_valid_q}, 16'h7ddf);
		check(np_to_mac_valid_q, 1'b0);
		stop_test();
	end
endmodule : media_mode_select_tb_top
bind media_mode_select media_mode_select_props i_media_mode_select_props (.*);
